// File: verilog/pll_ctrl_params.svh
`ifndef PLL_CTRL_PARAMS_SVH
`define PLL_CTRL_PARAMS_SVH

// Register offsets (byte addresses)
`define OFS_GRAPHICS 8'h38
`define OFS_DISPLAY_SERIAL 8'h40
`define OFS_INTERCHIP_USB 8'h44
`define OFS_DISPLAY_ENGINE 8'h48
`define OFS_MEMORY_B 8'h4c

// Reset values
`define RST_GRAPHICS 32'h03006207
`define RST_DISPLAY_SERIAL 32'h00000502
`define RST_INTERCHIP_USB 32'h03001300
`define RST_DISPLAY_ENGINE 32'h03006207
`define RST_MEMORY_B 32'h00001800

// Writable bit masks
`define WMASK_FRAC_PLL 32'h83107f0f
`define WMASK_DISPLAY_SERIAL 32'h8ef30f3f
`define WMASK_MEMORY_B 32'hc1003f00

// Common field positions
`define BIT_ENABLE 31
`define BIT_APPLY 30
`define BIT_LOCK 28
`define BIT_FRAC_ALT 27
`define BIT_DOUBLER 26
`define BIT_FREQ_PICK 25
`define BIT_INT_MODE 24
`define BIT_FB_DIV 17
`define BIT_FB_SEL 16
`define N7_HI 14
`define N6_HI 13
`define N4_HI 11
`define N_LO 8
`define K_HI 5
`define K_LO 4
`define M_HI 3
`define M_LO 0

// Lock settling time
`define LOCK_TIME_NS 20000
`define CLK_PERIOD_NS 10

`endif

// File: verilog/pll_ctrl_pkg.sv
package pll_ctrl_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Effective settings presented to one analog PLL
    typedef struct packed {
        logic enable;
        logic integer_mode;
        logic freq_pick;
        logic [7:0] mult_n;
        logic [4:0] mult_k;
        logic [4:0] div_m;
        logic alt_path;
        logic alt_frac;
        logic doubler;
        logic fb_div_by7;
    } pll_setting_t;

    typedef enum logic [1:0] {
        LK_OFF = 2'b00,
        LK_SETTLE = 2'b01,
        LK_LOCKED = 2'b10
    } lock_state_t;

endpackage : pll_ctrl_pkg

// File: verilog/pll_control_registers.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "pll_ctrl_params.svh"

module pll_lock_timer #(
    parameter int SETTLE_CYCLES = 2000
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic enable_i,
    input wire logic restart_i,
    // Status
    output logic locked_o
);
    import pll_ctrl_pkg::*;

    // Wide enough for the last settle count
    localparam int CW = $clog2(SETTLE_CYCLES + 1);

    lock_state_t state;
    logic [CW-1:0] count;
    logic settled;

    // A zero settle time would lock in the cycle of the enable
    if (SETTLE_CYCLES < 1) begin : gen_bad_settle
        $error("SETTLE_CYCLES must be at least one");
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= LK_OFF;
        end else if (!enable_i) begin
            state <= LK_OFF;
        end else if (restart_i || state == LK_OFF) begin
            state <= LK_SETTLE;
        end else begin
            case (state)
                LK_SETTLE: begin
                    if (settled) begin
                        state <= LK_LOCKED;
                    end
                end
                LK_LOCKED: state <= LK_LOCKED;
                // Stray codes fall back to unlocked
                default: state <= LK_OFF;
            endcase
        end
    end

    // Counter only runs while settling; it holds no meaning otherwise
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else if (!enable_i || restart_i || state != LK_SETTLE) begin
            count <= '0;
        end else if (!settled) begin
            count <= count + CW'(1);
        end
    end

    assign settled = (count >= CW'(SETTLE_CYCLES - 1));

    // lock flag
    // Modelled by a settle timer; the analog loop reports nothing here
    assign locked_o = (state == LK_LOCKED);

endmodule : pll_lock_timer

module frac_pll_decode (
    // Register image
    input wire logic [31:0] control_i,
    // Settings to the analog PLL
    output pll_ctrl_pkg::pll_setting_t setting_o
);
    import pll_ctrl_pkg::*;

    always_comb begin
        setting_o = '0;
        setting_o.enable = control_i[`BIT_ENABLE];
        setting_o.integer_mode = control_i[`BIT_INT_MODE];
        setting_o.freq_pick = control_i[`BIT_FREQ_PICK] & ~control_i[`BIT_INT_MODE];
        setting_o.mult_n = {1'b0, control_i[`N7_HI:`N_LO]} + 8'h1;
        setting_o.div_m = {1'b0, control_i[`M_HI:`M_LO]} + 5'h1;
        // K is fixed at one for these loops
        setting_o.mult_k = 5'h1;
    end

endmodule : frac_pll_decode

module pll_control_registers #(
    parameter int LOCK_CYCLES = (`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire pll_ctrl_pkg::reg_req_t req_i,
    output logic [31:0] rdata_o,
    // Settings to the analog PLLs
    output pll_ctrl_pkg::pll_setting_t graphics_pll_o,
    output pll_ctrl_pkg::pll_setting_t display_serial_pll_o,
    output pll_ctrl_pkg::pll_setting_t interchip_usb_pll_o,
    output pll_ctrl_pkg::pll_setting_t display_engine_pll_o,
    output pll_ctrl_pkg::pll_setting_t memory_pll_b_o,
    // Lock flags
    output logic [4:0] lock_o
);
    import pll_ctrl_pkg::*;

    // Lock flag order: graphics, serial, usb, engine, memory B
    localparam int NUM_PLL = 5;

    // Software views; the analog PLLs see them through the decoders, memory PLL B only through its applied copy
    logic [31:0] graphics_pll_control;
    logic [31:0] display_serial_pll_control;
    logic [31:0] interchip_usb_pll_control;
    logic [31:0] display_engine_pll_control;
    logic [31:0] memory_pll_b_control;
    logic [31:0] memory_b_applied;
    logic [NUM_PLL-1:0] wr_hit;
    logic [NUM_PLL-1:0] enables;
    logic [NUM_PLL-1:0] restarts;
    logic [NUM_PLL-1:0] locks;
    logic [31:0] next_rdata;
    logic apply_now;

    // Lock timers are built with this count
    if (LOCK_CYCLES < 1) begin : gen_bad_lock
        $error("LOCK_CYCLES must be at least one");
    end

    // Full byte address compare; aliases of the offsets reach nothing
    assign wr_hit[0] = req_i.wr && req_i.addr == `OFS_GRAPHICS;
    assign wr_hit[1] = req_i.wr && req_i.addr == `OFS_DISPLAY_SERIAL;
    assign wr_hit[2] = req_i.wr && req_i.addr == `OFS_INTERCHIP_USB;
    assign wr_hit[3] = req_i.wr && req_i.addr == `OFS_DISPLAY_ENGINE;
    assign wr_hit[4] = req_i.wr && req_i.addr == `OFS_MEMORY_B;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            graphics_pll_control <= `RST_GRAPHICS;
        end else if (wr_hit[0]) begin
            graphics_pll_control <= req_i.wdata & `WMASK_FRAC_PLL;
        end
    end

    // Source and regulator bits are stored for software only
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            display_serial_pll_control <= `RST_DISPLAY_SERIAL;
        end else if (wr_hit[1]) begin
            display_serial_pll_control <= req_i.wdata & `WMASK_DISPLAY_SERIAL;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interchip_usb_pll_control <= `RST_INTERCHIP_USB;
        end else if (wr_hit[2]) begin
            interchip_usb_pll_control <= req_i.wdata & `WMASK_FRAC_PLL;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            display_engine_pll_control <= `RST_DISPLAY_ENGINE;
        end else if (wr_hit[3]) begin
            display_engine_pll_control <= req_i.wdata & `WMASK_FRAC_PLL;
        end
    end

    // Apply once the request bit has been seen for a cycle
    assign apply_now = memory_pll_b_control[`BIT_APPLY];

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            memory_pll_b_control <= `RST_MEMORY_B;
        end else if (wr_hit[4]) begin
            // A new request written now wins over the self-clear
            memory_pll_b_control <= req_i.wdata & `WMASK_MEMORY_B;
        end else if (apply_now) begin
            memory_pll_b_control[`BIT_APPLY] <= 1'b0;
        end
    end

    // Analog side only ever sees the applied copy
    // Writing zero to the apply bit only stores the new factors
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            memory_b_applied <= `RST_MEMORY_B;
        end else if (apply_now) begin
            memory_b_applied <= memory_pll_b_control;
        end
    end

    // Same decode for the three fractional-capable PLLs
    frac_pll_decode u_graphics_decode (
        .control_i(graphics_pll_control),
        .setting_o(graphics_pll_o)
    );

    frac_pll_decode u_interchip_usb_decode (
        .control_i(interchip_usb_pll_control),
        .setting_o(interchip_usb_pll_o)
    );

    frac_pll_decode u_display_engine_decode (
        .control_i(display_engine_pll_control),
        .setting_o(display_engine_pll_o)
    );

    // Alternate path fields read as zero while factors are in use
    // display-serial path
    always_comb begin
        display_serial_pll_o = '0;
        display_serial_pll_o.enable = display_serial_pll_control[`BIT_ENABLE];
        display_serial_pll_o.alt_path = display_serial_pll_control[`BIT_FB_SEL];
        display_serial_pll_o.integer_mode = 1'b1;
        if (!display_serial_pll_control[`BIT_FB_SEL]) begin
            display_serial_pll_o.mult_n = {4'h0, display_serial_pll_control[`N4_HI:`N_LO]}
                + 8'h1;
            display_serial_pll_o.mult_k = {3'h0, display_serial_pll_control[`K_HI:`K_LO]}
                + 5'h1;
            display_serial_pll_o.div_m = {1'b0, display_serial_pll_control[`M_HI:`M_LO]}
                + 5'h1;
        end else begin
            display_serial_pll_o.alt_frac = display_serial_pll_control[`BIT_FRAC_ALT];
            display_serial_pll_o.integer_mode = ~display_serial_pll_control[`BIT_FRAC_ALT];
            display_serial_pll_o.doubler = display_serial_pll_control[`BIT_DOUBLER];
            display_serial_pll_o.freq_pick = display_serial_pll_control[`BIT_FREQ_PICK]
                & display_serial_pll_control[`BIT_FRAC_ALT];
            display_serial_pll_o.fb_div_by7 = display_serial_pll_control[`BIT_FB_DIV];
        end
    end

    always_comb begin
        memory_pll_b_o = '0;
        memory_pll_b_o.enable = memory_b_applied[`BIT_ENABLE];
        memory_pll_b_o.integer_mode = 1'b1;
        // Factor passes raw, with no plus one
        memory_pll_b_o.mult_n = {2'h0, memory_b_applied[`N6_HI:`N_LO]};
        memory_pll_b_o.mult_k = 5'h1;
        memory_pll_b_o.div_m = 5'h1;
    end

    assign enables = {memory_b_applied[`BIT_ENABLE],
                      display_engine_pll_control[`BIT_ENABLE],
                      interchip_usb_pll_control[`BIT_ENABLE],
                      display_serial_pll_control[`BIT_ENABLE],
                      graphics_pll_control[`BIT_ENABLE]};
    // Memory PLL B relocks only when a config is really applied
    assign restarts = {apply_now, wr_hit[3:0]};

    // Any write to the first four registers restarts its timer, even with unchanged factors
    genvar g;
    generate
        for (g = 0; g < NUM_PLL; g++) begin : gen_lock
            pll_lock_timer #(
                .SETTLE_CYCLES(LOCK_CYCLES)
            ) u_lock (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .enable_i(enables[g]),
                .restart_i(restarts[g]),
                .locked_o(locks[g])
            );
        end
    endgenerate

    // Level flags beside the read path for the clock tree users
    assign lock_o = locks;

    // lock in read data
    // Lock bit is never stored; it is merged on the way out
    always_comb begin
        next_rdata = 32'h0;
        if (req_i.rd) begin
            case (req_i.addr)
                `OFS_GRAPHICS: next_rdata = graphics_pll_control
                    | (32'(locks[0]) << `BIT_LOCK);
                `OFS_DISPLAY_SERIAL: next_rdata = display_serial_pll_control
                    | (32'(locks[1]) << `BIT_LOCK);
                `OFS_INTERCHIP_USB: next_rdata = interchip_usb_pll_control
                    | (32'(locks[2]) << `BIT_LOCK);
                `OFS_DISPLAY_ENGINE: next_rdata = display_engine_pll_control
                    | (32'(locks[3]) << `BIT_LOCK);
                `OFS_MEMORY_B: next_rdata = memory_pll_b_control
                    | (32'(locks[4]) << `BIT_LOCK);
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // Read data stand for one cycle only, then fall back to zero
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0;
        end else begin
            rdata_o <= next_rdata;
        end
    end

endmodule : pll_control_registers

// File: testbench/pll_ctrl_checker.sv
`timescale 1ns/1ps
`include "pll_ctrl_params.svh"
module pll_ctrl_checker #(
    parameter int LOCK_CYCLES = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire pll_ctrl_pkg::reg_req_t req_i,
    input wire logic [31:0] rdata_o,
    // Settings and lock
    input wire pll_ctrl_pkg::pll_setting_t graphics_pll_o,
    input wire pll_ctrl_pkg::pll_setting_t display_serial_pll_o,
    input wire pll_ctrl_pkg::pll_setting_t memory_pll_b_o,
    input wire logic [4:0] lock_o
);
    import pll_ctrl_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_rdata_idle;
        !$past(req_i.rd) |-> rdata_o == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_gfx_ranges;
        graphics_pll_o.mult_n inside {[1:128]} && graphics_pll_o.div_m inside {[1:16]};
    endproperty
    a_gfx_ranges: assert property (p_gfx_ranges) else $error("graphics factor out of range");
    property p_int_no_pick;
        graphics_pll_o.integer_mode |-> !graphics_pll_o.freq_pick;
    endproperty
    a_int_no_pick: assert property (p_int_no_pick) else $error("pick acts in integer mode");
    property p_lock_off;
        !$past(graphics_pll_o.enable) |-> !lock_o[0];
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock while disabled");
    property p_memb_lock_off;
        !$past(memory_pll_b_o.enable) |-> !lock_o[4];
    endproperty
    a_memb_lock_off: assert property (p_memb_lock_off) else $error("memory lock while off");
    property p_lock_rise;
        $rose(lock_o[0]) |-> $past(graphics_pll_o.enable, LOCK_CYCLES);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock rose too early");
    property p_alt_ignores;
        display_serial_pll_o.alt_path |-> display_serial_pll_o.mult_n == 8'h0
            && display_serial_pll_o.mult_k == 5'h0 && display_serial_pll_o.div_m == 5'h0;
    endproperty
    a_alt_ignores: assert property (p_alt_ignores) else $error("factors live in alt path");
    property p_alt_bits_idle;
        !display_serial_pll_o.alt_path |-> !display_serial_pll_o.alt_frac
            && !display_serial_pll_o.doubler && !display_serial_pll_o.fb_div_by7;
    endproperty
    a_alt_bits_idle: assert property (p_alt_bits_idle) else $error("alt bits act");
    property p_ratio_pick;
        display_serial_pll_o.freq_pick |-> display_serial_pll_o.alt_path
            && display_serial_pll_o.alt_frac;
    endproperty
    a_ratio_pick: assert property (p_ratio_pick) else $error("ratio pick misapplied");
    property p_memb_apply;
        $changed(memory_pll_b_o) |-> $past(req_i.wr && req_i.addr == `OFS_MEMORY_B
            && req_i.wdata[`BIT_APPLY], 2);
    endproperty
    a_memb_apply: assert property (p_memb_apply) else $error("memory change without apply");

    c_lock: cover property ($rose(lock_o[0]));
    c_alt: cover property (display_serial_pll_o.alt_path && display_serial_pll_o.doubler);
    c_apply: cover property ($changed(memory_pll_b_o));
endmodule : pll_ctrl_checker

bind pll_control_registers pll_ctrl_checker #(.LOCK_CYCLES(LOCK_CYCLES)) i_chk (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req_i),
    .rdata_o(rdata_o),
    .graphics_pll_o(graphics_pll_o),
    .display_serial_pll_o(display_serial_pll_o),
    .memory_pll_b_o(memory_pll_b_o),
    .lock_o(lock_o)
);

// File: testbench/tb.sv
`timescale 1ns/1ps
`include "pll_ctrl_params.svh"
module tb;
    import pll_ctrl_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    logic sys_clk_i;
    logic rst_n_i = 1'b0;
    reg_req_t req_i = '0;
    logic [31:0] rdata_o;
    pll_setting_t gfx, ser, usb, de, memb;
    logic [4:0] lock_o;
    int errors = 0;
    int checks = 0;
    // Complement of a mask proves unused bits hold nothing
    row_t rows [6] = '{'{`OFS_GRAPHICS, 32'hffffffff, 32'h83107f0f},
        '{`OFS_DISPLAY_SERIAL, 32'hffffffff, 32'h8ef30f3f}, '{`OFS_INTERCHIP_USB, 32'h0, 32'h0},
        '{`OFS_DISPLAY_ENGINE, 32'h7cef80f0, 32'h0}, '{`OFS_MEMORY_B, 32'hbfffffff, 32'h81003f00},
        '{8'h50, 32'hffffffff, 32'h0}};

    pll_control_registers #(.LOCK_CYCLES(4)) i_dut (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .req_i(req_i),
        .rdata_o(rdata_o),
        .graphics_pll_o(gfx),
        .display_serial_pll_o(ser),
        .interchip_usb_pll_o(usb),
        .display_engine_pll_o(de),
        .memory_pll_b_o(memb),
        .lock_o(lock_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
        req_i.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        req_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_i);
        req_i.rd <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd(`OFS_GRAPHICS, `RST_GRAPHICS);
        rd(`OFS_DISPLAY_SERIAL, `RST_DISPLAY_SERIAL);
        rd(`OFS_INTERCHIP_USB, 32'h03001300);
        rd(`OFS_DISPLAY_ENGINE, `RST_DISPLAY_ENGINE);
        rd(`OFS_MEMORY_B, `RST_MEMORY_B);
        chk({usb.mult_n, usb.div_m, usb.integer_mode}, {8'h14, 5'h1, 1'b1});
        chk(lock_o, 5'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk(memb.enable, 1'b0);
        // factors keep the graphics and engine outputs within range
        wr(`OFS_GRAPHICS, 32'h81007f0f);
        chk({gfx.mult_n, gfx.div_m, gfx.integer_mode}, {8'h80, 5'h10, 1'b1});
        wr(`OFS_DISPLAY_ENGINE, 32'h81001f03);
        chk({de.enable, de.mult_n, de.div_m, de.freq_pick}, {1'b1, 8'h20, 5'h4, 1'b0});
        wr(`OFS_GRAPHICS, 32'h82000000);
        chk({gfx.freq_pick, gfx.mult_n, gfx.div_m}, {1'b1, 8'h1, 5'h1});
        wr(`OFS_GRAPHICS, 32'h83000200);
        chk({gfx.freq_pick, gfx.integer_mode}, 2'b01);
        repeat (8) @(posedge sys_clk_i);
        chk(lock_o[0], 1'b1);
        rd(`OFS_GRAPHICS, 32'h93000200);
        wr(`OFS_GRAPHICS, 32'h83000100);
        rd(`OFS_GRAPHICS, 32'h83000100);
        wr(`OFS_GRAPHICS, 32'h03000000);
        repeat (8) @(posedge sys_clk_i);
        rd(`OFS_GRAPHICS, 32'h03000000);
        wr(`OFS_DISPLAY_SERIAL, 32'h80000f3f);
        chk({ser.mult_n, ser.mult_k, ser.div_m}, {8'h10, 5'h4, 5'h10});
        wr(`OFS_DISPLAY_SERIAL, 32'h8e030f3f);
        chk({ser.alt_frac, ser.doubler, ser.freq_pick, ser.fb_div_by7}, 4'hf);
        chk({ser.alt_path, ser.mult_n, ser.integer_mode}, {1'b1, 8'h0, 1'b0});
        wr(`OFS_DISPLAY_SERIAL, 32'h80010000);
        chk({ser.doubler, ser.fb_div_by7, ser.integer_mode}, 3'b001);
        // factor passes raw, applied a cycle after the write
        wr(`OFS_MEMORY_B, 32'hc0001e00);
        @(posedge sys_clk_i);
        #1;
        chk({memb.enable, memb.mult_n}, {1'b1, 8'h1e});
        rd(`OFS_MEMORY_B, 32'h80001e00);
        end_of_test();
    end

    initial begin
        #200000;
        errors++;
        end_of_test();
    end
endmodule : tb
